/* core/csd_top.sv */
// Counter settings, display colour, panel prompt and serial link logic
`timescale 1ns/1ps
`include "csd_defines.svh"
//Contract
// - Serial enable setting: none or fitted
// - Link address 1 to 99, default 1
// - Address and speed shown only when link usable
// - Four link speeds, default 4800
// - Frames: start, seven data, even parity, stop
// - Four colour choices; fixed ones never change
// - Green until reached, then red; default
// - Red until reached, then green
// - Preset lock makes presets panel read-only
// - Help on: name, value after 3 s or scroll
// - Help off: value only, one-character legend
// - Drive two-colour display and two lamps
// - Count up to 10 kHz, four modes
// - Control inputs edge-sensitive, answer within 25 ms
// - Input one resets count, two locks out
// - Outputs switch within 75 us
// - Batch reaching preset drives output two
// - Locked presets refuse entering digit edit
module csd_top
#(
    parameter int HELP_CYC = `CSD_HELP_CYC
)
(
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic [`CSD_AW-1:0]      reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rdata,
    input  wire logic                    count_a,
    input  wire logic                    count_b,
    input  wire logic                    ctl_in1,
    input  wire logic                    ctl_in2,
    input  wire logic                    key_pgm,
    input  wire logic                    key_scroll,
    input  wire logic                    board_fitted,
    input  wire logic                    ser_rx,
    output logic                         ser_tx,
    output logic                         ser_de_n,
    output logic                         irq,
    output logic      [16:0]             disp_value,
    output csd_pkg::csd_front_type       front,
    output csd_pkg::csd_panel_type       panel
);
    import csd_pkg::*;

    function automatic logic [16:0] wrap_inc(input logic [16:0] v);
        wrap_inc = (v == `CSD_COUNT_MAX) ? 17'h00000 : v + 17'h00001;
    endfunction

    function automatic logic [16:0] wrap_dec(input logic [16:0] v);
        wrap_dec = (v == 17'h00000) ? `CSD_COUNT_MAX : v - 17'h00001;
    endfunction

    function automatic logic [13:0] baud_div(input csd_baud_type s);
        unique case (s)
            BAUD_1200: baud_div = 14'(`CSD_CLK_HZ / `CSD_BAUD_1200 - 1);
            BAUD_2400: baud_div = 14'(`CSD_CLK_HZ / `CSD_BAUD_2400 - 1);
            BAUD_4800: baud_div = 14'(`CSD_CLK_HZ / `CSD_BAUD_4800 - 1);
            BAUD_9600: baud_div = 14'(`CSD_CLK_HZ / `CSD_BAUD_9600 - 1);
        endcase
    endfunction

    logic [`CSD_PIN_N-1:0]   pin_raw;
    logic [`CSD_PIN_N-1:0]   pin_s1;
    logic [`CSD_PIN_N-1:0]   pin_s2;
    logic [`CSD_PIN_N-1:0]   pin_d;
    logic [`CSD_PIN_N-1:0]   pin_rise;
    logic [`CSD_PIN_N-1:0]   pin_fall;
    csd_cfg_type             cfg;
    logic [6:0]              link_addr;
    logic [16:0]             preset1;
    logic [16:0]             batch_preset;
    logic [16:0]             count;
    logic [16:0]             batch;
    logic                    reached;
    logic                    reached_d;
    logic                    preset_hit;
    logic                    cnt_up;
    logic                    cnt_dn;
    logic                    sec_lock;
    logic                    locked;
    logic                    link_active;
    logic                    link_ok;
    logic [`CSD_INT_W-1:0]   int_status;
    logic [`CSD_INT_W-1:0]   int_mask;
    logic [`CSD_INT_W-1:0]   events;
    logic [`CSD_INT_W-1:0]   next_status;
    csd_panel_state_type     pstate;
    logic [2:0]              param;
    logic [24:0]             help_cnt;
    logic [2:0]              digit;
    logic                    tx_busy;
    logic                    tx_start;
    logic                    tx_done;
    logic [8:0]              tx_shift;
    logic [3:0]              tx_bits;
    logic [13:0]             tx_cnt;
    logic                    rx_busy;
    logic [3:0]              rx_bits;
    logic [13:0]             rx_cnt;
    logic [8:0]              rx_shift;
    logic [7:0]              rx_data;
    logic                    rx_ready;
    logic                    rx_err;
    logic [31:0]             rd_mux;
    logic [13:0]             bit_div;

    // Every pin passes two flip-flops before use
    assign pin_raw = {board_fitted, ser_rx, key_scroll, key_pgm, ctl_in2, ctl_in1, count_b, count_a};

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_d  <= '0;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end

    assign pin_rise = pin_s2 & ~pin_d;
    assign pin_fall = ~pin_s2 & pin_d;
    assign link_active = cfg.serial_en & pin_s2[`CSD_PIN_BOARD];
    assign link_ok = link_active;
    assign bit_div = baud_div(cfg.baud);
    assign locked = cfg.lock | sec_lock;

    // Settings registers written by software
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            cfg          <= csd_cfg_type'(`CSD_CFG_RST);
            link_addr    <= `CSD_ADDR_RST;
            preset1      <= `CSD_PRESET_RST;
            batch_preset <= `CSD_PRESET_RST;
            int_mask     <= '0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `CSD_A_CONFIG:    cfg <= csd_cfg_type'(reg_wdata[`CSD_CFG_W-1:0]);
                `CSD_A_LINK_ADDR:
                    if (reg_wdata[6:0] >= `CSD_ADDR_MIN && reg_wdata[6:0] <= `CSD_ADDR_MAX && reg_wdata[31:7] == '0)
                        link_addr <= reg_wdata[6:0];
                `CSD_A_PRESET1:   preset1 <= reg_wdata[16:0];
                `CSD_A_BATCH_PRE: batch_preset <= reg_wdata[16:0];
                `CSD_A_INT_MASK:  int_mask <= reg_wdata[`CSD_INT_W-1:0];
                default: ;
            endcase
        end

    // Count step from the selected count mode
    always_comb
    begin
        cnt_up = 1'b0;
        cnt_dn = 1'b0;
        unique case (cfg.cnt_mode)
            CNT_SUM:  cnt_up = pin_rise[`CSD_PIN_A] | pin_rise[`CSD_PIN_B];
            CNT_DIFF:
            begin
                cnt_up = pin_rise[`CSD_PIN_A] & ~pin_rise[`CSD_PIN_B];
                cnt_dn = pin_rise[`CSD_PIN_B] & ~pin_rise[`CSD_PIN_A];
            end
            CNT_DIR, CNT_QUAD:
            begin
                cnt_up = pin_rise[`CSD_PIN_A] & ~pin_s2[`CSD_PIN_B];
                cnt_dn = pin_rise[`CSD_PIN_A] & pin_s2[`CSD_PIN_B];
            end
        endcase
    end

    // Count with auto reset at preset one and remote reset on input one
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            count      <= '0;
            preset_hit <= 1'b0;
        end
        else
        begin
            preset_hit <= 1'b0;
            if (pin_rise[`CSD_PIN_CTL1])
                count <= '0;
            else if (cnt_up && wrap_inc(count) >= preset1)
            begin
                count      <= '0;
                preset_hit <= 1'b1;
            end
            else if (cnt_up)
                count <= wrap_inc(count);
            else if (cnt_dn)
                count <= wrap_dec(count);
        end

    // Batch count and reached condition
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            batch     <= '0;
            reached_d <= 1'b0;
        end
        else
        begin
            if (preset_hit)
                batch <= wrap_inc(batch);
            reached_d <= reached;
        end

    assign reached = (batch >= batch_preset);

    // Security lockout follows the edges of input two
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            sec_lock <= 1'b0;
        else if (pin_rise[`CSD_PIN_CTL2])
            sec_lock <= 1'b1;
        else if (pin_fall[`CSD_PIN_CTL2])
            sec_lock <= 1'b0;

    // Outputs, lamps and display colour
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            front      <= '0;
            disp_value <= '0;
        end
        else
        begin
            front.out1   <= preset_hit;
            front.out2   <= reached;
            front.relay2 <= reached;
            front.lamp1  <= preset_hit;
            front.lamp2  <= reached;
            disp_value   <= count;
            unique case (cfg.colour)
                COL_FIXED_RED:         {front.red, front.green} <= 2'h2;
                COL_FIXED_GREEN:       {front.red, front.green} <= 2'h1;
                COL_GREEN_THEN_RED:    {front.red, front.green} <= reached ? 2'h2 : 2'h1;
                RED_THEN_GREEN_CHOICE: {front.red, front.green} <= reached ? 2'h1 : 2'h2;
            endcase
        end

    // Front panel parameter walk and prompt timing
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            pstate   <= PS_IDLE;
            param    <= `CSD_PARAM_SERIAL;
            help_cnt <= '0;
            digit    <= '0;
        end
        else
        begin
            help_cnt <= (pstate == PS_NAME && !pin_rise[`CSD_PIN_PGM] && !pin_rise[`CSD_PIN_SCROLL])
                ? help_cnt + 25'h0000001 : 25'h0000000;
            unique case (pstate)
                PS_IDLE:
                    if (pin_rise[`CSD_PIN_PGM])
                    begin
                        param  <= `CSD_PARAM_SERIAL;
                        pstate <= (cfg.help == `CSD_PROMPT_OFF_CHOICE) ? PS_VALUE : PS_NAME;
                    end
                PS_NAME, PS_VALUE:
                    if (pin_rise[`CSD_PIN_PGM])
                    begin
                        if (param == `CSD_PARAM_HELP)
                            pstate <= PS_IDLE;
                        else
                        begin
                            if (!link_ok && param == `CSD_PARAM_SERIAL)
                                param <= `CSD_PARAM_COLOUR;
                            else
                                param <= param + 3'h1;
                            pstate <= (cfg.help == `CSD_PROMPT_OFF_CHOICE) ? PS_VALUE : PS_NAME;
                        end
                    end
                    else if (pin_rise[`CSD_PIN_SCROLL])
                    begin
                        digit  <= '0;
                        pstate <= locked ? PS_VALUE : PS_EDIT;
                    end
                    else if (pstate == PS_NAME && help_cnt >= 25'(HELP_CYC - 1))
                        pstate <= PS_VALUE;
                PS_EDIT:
                    if (pin_rise[`CSD_PIN_PGM])
                        pstate <= PS_VALUE;
                    else if (pin_rise[`CSD_PIN_SCROLL])
                        digit <= (digit == `CSD_LAST_DIGIT) ? 3'h0 : digit + 3'h1;
            endcase
        end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            panel <= '0;
        else
        begin
            panel.show_name   <= (pstate == PS_NAME);
            panel.edit_active <= (pstate == PS_EDIT);
            panel.edit_digit  <= digit;
            panel.param_sel   <= param;
            panel.legend      <= (pstate == PS_IDLE) ? 4'h0 : {1'b0, param} + 4'h1;
        end

    // Serial transmitter: start, seven data, even parity, stop
    assign tx_start = reg_wr && reg_addr == `CSD_A_TX_DATA && link_active && !tx_busy;

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            tx_busy  <= 1'b0;
            tx_done  <= 1'b0;
            tx_shift <= '1;
            tx_bits  <= '0;
            tx_cnt   <= '0;
            ser_tx   <= 1'b1;
            ser_de_n <= 1'b1;
        end
        else
        begin
            tx_done <= 1'b0;
            if (!link_active)
            begin
                tx_busy  <= 1'b0;
                ser_tx   <= 1'b1;
                ser_de_n <= 1'b1;
            end
            else if (tx_start)
            begin
                tx_busy  <= 1'b1;
                ser_tx   <= 1'b0;
                ser_de_n <= 1'b0;
                tx_shift <= {1'b1, ^reg_wdata[6:0], reg_wdata[6:0]};
                tx_bits  <= `CSD_FRAME_BITS;
                tx_cnt   <= baud_div(cfg.baud);
            end
            else if (tx_busy)
            begin
                if (tx_cnt != 14'h0000)
                    tx_cnt <= tx_cnt - 14'h0001;
                else if (tx_bits != 4'h0)
                begin
                    ser_tx   <= tx_shift[0];
                    tx_shift <= {1'b1, tx_shift[8:1]};
                    tx_bits  <= tx_bits - 4'h1;
                    tx_cnt   <= baud_div(cfg.baud);
                end
                else
                begin
                    tx_busy  <= 1'b0;
                    tx_done  <= 1'b1;
                    ser_de_n <= 1'b1;
                end
            end
        end

    // Serial receiver sampling mid-bit
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            rx_busy  <= 1'b0;
            rx_bits  <= '0;
            rx_cnt   <= '0;
            rx_shift <= '0;
            rx_data  <= '0;
            rx_ready <= 1'b0;
            rx_err   <= 1'b0;
        end
        else
        begin
            rx_ready <= 1'b0;
            rx_err   <= 1'b0;
            if (!link_active)
                rx_busy <= 1'b0;
            else if (!rx_busy)
            begin
                if (pin_fall[`CSD_PIN_RX])
                begin
                    rx_busy <= 1'b1;
                    rx_bits <= '0;
                    rx_cnt  <= {1'b0, bit_div[13:1]};
                end
            end
            else if (rx_cnt != 14'h0000)
                rx_cnt <= rx_cnt - 14'h0001;
            else
            begin
                rx_cnt <= baud_div(cfg.baud);
                if (rx_bits == 4'h0 && pin_s2[`CSD_PIN_RX])
                    rx_busy <= 1'b0;
                else if (rx_bits == `CSD_FRAME_BITS)
                begin
                    rx_busy  <= 1'b0;
                    rx_data  <= {1'b0, rx_shift[7:1]};
                    rx_ready <= 1'b1;
                    rx_err   <= (^rx_shift[8:1]) | ~pin_s2[`CSD_PIN_RX];
                end
                else
                begin
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_bits != 4'h0)
                        rx_shift <= {pin_s2[`CSD_PIN_RX], rx_shift[8:1]};
                end
            end
        end

    // Interrupt status, set wins over clear
    always_comb
    begin
        events = '0;
        events[`CSD_INT_REACHED]   = reached & ~reached_d;
        events[`CSD_INT_PRESET1]   = preset_hit;
        events[`CSD_INT_RX_READY]  = rx_ready;
        events[`CSD_INT_RX_ERR]    = rx_err;
        events[`CSD_INT_TX_DONE]   = tx_done;
        events[`CSD_INT_CTL_RESET] = pin_rise[`CSD_PIN_CTL1];
        next_status = int_status;
        if (reg_wr && reg_addr == `CSD_A_INT_STAT)
            next_status = next_status & ~reg_wdata[`CSD_INT_W-1:0];
        next_status = next_status | events;
    end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            int_status <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            int_status <= next_status;
            irq        <= |(next_status & int_mask);
        end

    // Read data stand one cycle after the strobe
    always_comb
    begin
        rd_mux = '0;
        unique case (reg_addr)
            `CSD_A_CONFIG:    rd_mux[`CSD_CFG_W-1:0] = cfg;
            `CSD_A_LINK_ADDR: rd_mux[6:0] = link_addr;
            `CSD_A_PRESET1:   rd_mux[16:0] = preset1;
            `CSD_A_BATCH_PRE: rd_mux[16:0] = batch_preset;
            `CSD_A_COUNT:     rd_mux[16:0] = count;
            `CSD_A_BATCH:     rd_mux[16:0] = batch;
            `CSD_A_STATUS:    rd_mux[13:0] = {pstate, param, tx_busy, rx_busy, link_active,
                                              pin_s2[`CSD_PIN_BOARD], sec_lock, locked, reached};
            `CSD_A_INT_STAT:  rd_mux[`CSD_INT_W-1:0] = int_status;
            `CSD_A_INT_MASK:  rd_mux[`CSD_INT_W-1:0] = int_mask;
            `CSD_A_RX_DATA:   rd_mux[7:0] = rx_data;
            default:          rd_mux = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
        if (rst)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_addr_range: assert property (link_addr >= `CSD_ADDR_MIN && link_addr <= `CSD_ADDR_MAX)
        else $error("link address out of range");
    a_link_silent: assert property (!link_active |=> ser_tx && ser_de_n && !rx_ready)
        else $error("link active while disabled");
    a_tx_frame_start: assert property (tx_start |=> !ser_tx && !ser_de_n && tx_bits == `CSD_FRAME_BITS)
        else $error("frame start bit wrong");
    a_fixed_colour: assert property (cfg.colour == COL_FIXED_RED |=> front.red && !front.green)
        else $error("fixed red colour lost");
    a_green_red: assert property (cfg.colour == COL_GREEN_THEN_RED && !reached |=> front.green && !front.red)
        else $error("green before reached expected");
    a_red_green: assert property (cfg.colour == RED_THEN_GREEN_CHOICE && reached |=> front.green && !front.red)
        else $error("green after reached expected");
    a_lock_edit: assert property (locked && pstate != PS_EDIT |=> pstate != PS_EDIT)
        else $error("edit entered while locked");
    a_skip_link: assert property (!link_ok && pstate != PS_IDLE && param == `CSD_PARAM_SERIAL && pin_rise[`CSD_PIN_PGM]
        |=> param == `CSD_PARAM_COLOUR)
        else $error("link settings not skipped");
    a_ctl_reset: assert property (pin_rise[`CSD_PIN_CTL1] |=> count == 17'h00000)
        else $error("remote reset not applied");
    a_out2_reached: assert property ($rose(reached) |=> front.out2 && front.relay2 && front.lamp2)
        else $error("output two late");
    a_name_first: assert property (pstate == PS_IDLE && pin_rise[`CSD_PIN_PGM] && cfg.help |=> pstate == PS_NAME ##1
        panel.show_name)
        else $error("name not shown first");
endmodule

/* core/csd_defines.svh */
// Register map, field layout, reset values and timing constants of the counter settings block
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
`define CSD_AW            6
`define CSD_A_CONFIG      6'h00
`define CSD_A_LINK_ADDR   6'h04
`define CSD_A_PRESET1     6'h08
`define CSD_A_BATCH_PRE   6'h0C
`define CSD_A_COUNT       6'h10
`define CSD_A_BATCH       6'h14
`define CSD_A_STATUS      6'h18
`define CSD_A_INT_STAT    6'h1C
`define CSD_A_INT_MASK    6'h20
`define CSD_A_TX_DATA     6'h24
`define CSD_A_RX_DATA     6'h28
`define CSD_CFG_W         9
`define CSD_CFG_RST       9'h054
`define CSD_ADDR_MIN      7'h01
`define CSD_ADDR_MAX      7'h63
`define CSD_ADDR_RST      7'h01
`define CSD_PRESET_RST    17'h0000A
`define CSD_COUNT_MAX     17'h1869F
`define CSD_INT_W         6
`define CSD_INT_REACHED   0
`define CSD_INT_PRESET1   1
`define CSD_INT_RX_READY  2
`define CSD_INT_RX_ERR    3
`define CSD_INT_TX_DONE   4
`define CSD_INT_CTL_RESET 5
`define CSD_PIN_N         8
`define CSD_PIN_A         0
`define CSD_PIN_B         1
`define CSD_PIN_CTL1      2
`define CSD_PIN_CTL2      3
`define CSD_PIN_PGM       4
`define CSD_PIN_SCROLL    5
`define CSD_PIN_RX        6
`define CSD_PIN_BOARD     7
`define CSD_CLK_HZ        10000000
`define CSD_CLK_NS        100
`define CSD_BAUD_1200     1200
`define CSD_BAUD_2400     2400
`define CSD_BAUD_4800     4800
`define CSD_BAUD_9600     9600
`define CSD_HELP_MS       3000
`define CSD_HELP_CYC      ((`CSD_HELP_MS) * (`CSD_CLK_HZ / 1000))
`define CSD_OUT_LAT_NS    75000
`define CSD_OUT_LAT_CYC   (`CSD_OUT_LAT_NS / `CSD_CLK_NS)
`define CSD_LAST_DIGIT    3'h4
`define CSD_FRAME_BITS    4'h9
`define CSD_PROMPT_OFF_CHOICE 1'h0
`define CSD_PARAM_SERIAL  3'h0
`define CSD_PARAM_ADDR    3'h1
`define CSD_PARAM_BAUD    3'h2
`define CSD_PARAM_COLOUR  3'h3
`define CSD_PARAM_LOCK    3'h4
`define CSD_PARAM_HELP    3'h5
`endif

/* core/csd_pkg.sv */
// Types shared by the counter settings block
package csd_pkg;
    typedef enum logic [1:0] {COL_FIXED_RED = 2'h0, COL_FIXED_GREEN = 2'h1,
        COL_GREEN_THEN_RED = 2'h2, RED_THEN_GREEN_CHOICE = 2'h3} csd_colour_type;
    typedef enum logic [1:0] {CNT_SUM = 2'h0, CNT_DIFF = 2'h1, CNT_DIR = 2'h2, CNT_QUAD = 2'h3} csd_cnt_mode_type;
    typedef enum logic [1:0] {BAUD_1200 = 2'h0, BAUD_2400 = 2'h1, BAUD_4800 = 2'h2, BAUD_9600 = 2'h3} csd_baud_type;
    typedef enum logic [3:0] {PS_IDLE = 4'h1, PS_NAME = 4'h2, PS_VALUE = 4'h4, PS_EDIT = 4'h8} csd_panel_state_type;
    typedef struct packed {
        csd_cnt_mode_type cnt_mode;
        logic             help;
        logic             lock;
        csd_colour_type   colour;
        csd_baud_type     baud;
        logic             serial_en;
    } csd_cfg_type;
    typedef struct packed {
        logic       show_name;
        logic       edit_active;
        logic [2:0] edit_digit;
        logic [2:0] param_sel;
        logic [3:0] legend;
    } csd_panel_type;
    typedef struct packed {
        logic out1;
        logic out2;
        logic relay2;
        logic lamp1;
        logic lamp2;
        logic red;
        logic green;
    } csd_front_type;
endpackage

/* test/csd_host.sv */
// Remote serial host model on the shared link
`timescale 1ns/1ps
module csd_host
#(
    parameter int BIT = 1041
)
(
    input  wire logic  mclk,
    input  wire logic  ser_tx,
    output logic       ser_rx,
    output logic [8:0] got,
    output int         n_got
);
    initial
    begin
        ser_rx = 1'b1;
        n_got = 0;
    end
    // Samples mid-bit: seven data, parity, stop
    always @(negedge ser_tx)
    begin
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT) @(posedge mclk);
            got[i] = ser_tx;
        end
        n_got++;
    end
    task automatic send(input logic [6:0] d);
        logic [9:0] f;
        f = {1'b1, ^d, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            ser_rx <= f[i];
            repeat (BIT) @(posedge mclk);
        end
    endtask
endmodule

/* test/tb_csd_top.sv */
// Self-checking bench of the counter settings block
`timescale 1ns/1ps
`include "csd_defines.svh"
module tb_csd_top;
    import csd_pkg::*;
    logic          mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, key_pgm = 1'b0, board_fitted = 1'b0;
    logic          key_scroll = 1'b0, ctl_in1 = 1'b0, ctl_in2 = 1'b0, count_a = 1'b0, de_n;
    logic [5:0]    reg_addr = 6'h00;
    logic [31:0]   reg_wdata = 32'h0, reg_rdata, v;
    logic [16:0]   disp;
    logic          ser_rx, ser_tx, irq;
    logic [8:0]    got;
    logic [6:0]    d;
    csd_front_type front;
    csd_panel_type panel;
    int            err_count = 0, checked = 0, n_got, seed = 32'h8FB2;
    always #50 mclk = ~mclk;
    csd_top #(.HELP_CYC(20)) dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_a(count_a), .count_b(1'b0),
        .ctl_in1(ctl_in1), .ctl_in2(ctl_in2), .key_pgm(key_pgm), .key_scroll(key_scroll),
        .board_fitted(board_fitted), .ser_rx(ser_rx), .ser_tx(ser_tx), .ser_de_n(de_n), .irq(irq),
        .disp_value(disp), .front(front), .panel(panel));
    csd_host #(.BIT(1041)) host (.mclk(mclk), .ser_tx(ser_tx), .ser_rx(ser_rx), .got(got), .n_got(n_got));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] w);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Pulses one key or pin: 0 program, 1 scroll, 2 input one, 3 count A
    task automatic press(input int k);
        case (k)
            0: key_pgm <= 1'b1;
            1: key_scroll <= 1'b1;
            2: ctl_in1 <= 1'b1;
            default: count_a <= 1'b1;
        endcase
        repeat (4) @(posedge mclk);
        {key_pgm, key_scroll, ctl_in1, count_a} <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask
    function automatic logic [31:0] cfg(input int c, input int b, input int s);
        return 32'(32'h40 + c * 8 + b * 2 + s);
    endfunction
    // Expected out2, red, green
    function automatic logic [2:0] col(input int c, input logic r);
        logic red;
        red = (c == 0) || (c == 2 && r) || (c == 3 && !r);
        return {r, red, !red};
    endfunction
    task automatic final_report;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge mclk);
        err_count++;
        final_report;
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rc(`CSD_A_CONFIG, 32'h54);
        rc(`CSD_A_LINK_ADDR, 32'h1);
        rc(6'h3C, 32'h0);
        v = 32'(1 + $unsigned($random(seed)) % 99);
        wr(`CSD_A_LINK_ADDR, 32'h63);
        wr(`CSD_A_LINK_ADDR, 32'h64);
        rc(`CSD_A_LINK_ADDR, 32'h63);
        wr(`CSD_A_LINK_ADDR, v);
        wr(`CSD_A_LINK_ADDR, 32'h0);
        rc(`CSD_A_LINK_ADDR, v);
        for (int c = 0; c < 4; c++)
        begin
            wr(`CSD_A_CONFIG, cfg(c, 2, 0));
            wr(`CSD_A_BATCH_PRE, 32'hA);
            repeat (3) @(posedge mclk);
            chk({front.out2, front.red, front.green}, col(c, 1'b0));
            wr(`CSD_A_BATCH_PRE, 32'h0);
            repeat (3) @(posedge mclk);
            chk({front.out2, front.red, front.green}, col(c, 1'b1));
        end
        chk(irq, 1'b0);
        wr(`CSD_A_INT_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        wr(`CSD_A_INT_STAT, 32'h1);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        board_fitted <= 1'b1;
        wr(`CSD_A_CONFIG, cfg(2, 3, 1));
        d = 7'($random(seed));
        wr(`CSD_A_TX_DATA, {25'h0, d});
        @(posedge mclk);
        chk(de_n, 1'b0);
        for (int i = 0; i < 12000 && n_got == 0; i++)
            @(posedge mclk);
        chk(got, {1'b1, ^d, d});
        d = 7'($random(seed));
        host.send(d);
        repeat (5) @(posedge mclk);
        rc(`CSD_A_RX_DATA, {25'h0, d});
        wr(`CSD_A_CONFIG, cfg(2, 3, 0));
        wr(`CSD_A_TX_DATA, 32'h41);
        host.send(~d);
        chk(n_got, 32'h1);
        chk({ser_tx, de_n}, 2'h3);
        rc(`CSD_A_RX_DATA, {25'h0, d});
        for (int i = 0; i < 2; i++)
        begin
            press(0);
            chk({panel.show_name, panel.param_sel}, i == 0 ? 4'h8 : 4'hB);
        end
        repeat (14) @(posedge mclk);
        chk(panel.show_name, 1'b1);
        repeat (11) @(posedge mclk);
        chk(panel.show_name, 1'b0);
        press(1);
        press(1);
        chk({panel.edit_active, panel.edit_digit}, 4'h9);
        press(0);
        ctl_in2 <= 1'b1;
        repeat (4) @(posedge mclk);
        press(1);
        chk(panel.edit_active, 1'b0);
        ctl_in2 <= 1'b0;
        for (int i = 0; i < 3; i++)
            press(3);
        rc(`CSD_A_COUNT, 32'h3);
        chk(disp, 17'h00003);
        press(2);
        rc(`CSD_A_COUNT, 32'h0);
        wr(`CSD_A_CONFIG, 32'h16);
        for (int i = 0; i < 4; i++)
            press(0);
        chk({panel.show_name, panel.legend}, 5'h01);
        final_report;
    end
endmodule
